// File: rtl/sdc_pkg.sv
// Purpose: Shared constants and types for the stall detector control block
// Assumes: AXI4-Lite register access, 32-bit data, register index times four
// Notes: Byte address of each register is its index times four
package sdc_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 5;
  localparam logic [2:0] IDX_RTZ_CONTROL = 3'h0;
  localparam logic [2:0] IDX_DOWN_COUNTER_CONTROL = 3'h1;
  localparam logic [2:0] IDX_STALL_CONTROL = 3'h2;
  localparam logic [2:0] IDX_FLAGS = 3'h3;
  localparam logic [2:0] IDX_DOWN_COUNTER_COUNT = 3'h4;

  // ==========================================================
  // Field positions
  localparam int unsigned BIT_INTEGRATE_SEL = 7;
  localparam int unsigned BIT_DRIVE_COIL_EN = 6;
  localparam int unsigned BIT_RECIRC_LOW_SIDE_SEL = 5;
  localparam int unsigned BIT_CONVERTER_POLARITY = 4;
  localparam int unsigned BIT_UNDERFLOW_IRQ_EN = 7;
  localparam int unsigned BIT_AUTO_RELOAD_EN = 6;
  localparam int unsigned BIT_READ_LOAD_SEL = 5;
  localparam int unsigned BIT_PRESCALE_SEL = 4;
  localparam int unsigned BIT_FORCE_LOAD = 3;
  localparam int unsigned BIT_DOWN_COUNTER_EN = 2;
  localparam int unsigned BIT_ACC_OVERFLOW_IRQ_EN = 0;
  localparam int unsigned BIT_RETURN_TO_ZERO_EN = 7;
  localparam int unsigned BIT_UNDERFLOW_FLAG = 7;
  localparam int unsigned BIT_ACC_OVERFLOW_FLAG = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] COUNT_IDLE = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] LOAD_RST = 16'h0000;
  localparam int unsigned PRESCALE_SLOW = 512;
  localparam int unsigned PRESCALE_FAST = 64;
  localparam logic [1:0] AXI_OKAY = 2'h0;

  // ==========================================================
  // Types
  typedef struct packed {
    logic integrate_sel;
    logic drive_coil_en;
    logic recirc_low_side_sel;
    logic converter_polarity;
    logic [1:0] step;
  } sdc_rtz_s;

  typedef struct packed {
    logic [7:0] transistor_on;
    logic [7:0] switch_close;
  } sdc_coil_s;

endpackage : sdc_pkg

// File: rtl/sdc_down_counter.sv
// Purpose: Prescaled sixteen-bit modulus down-counter
// Assumes: One clock, clock enable freezes all state
// Notes: Prescale choice is latched only when the count is loaded
`timescale 1ns/10ps
module sdc_down_counter #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic auto_reload_i,
  input wire logic div_slow_i,
  input wire logic wr_i,
  input wire logic [CNT_W-1:0] wr_data_i,
  input wire logic force_load_i,
  output logic [CNT_W-1:0] count_o,
  output logic [CNT_W-1:0] load_o,
  output logic zero_hit_o
);

  logic [8:0] pre_q;
  logic div_slow_q;
  logic tick;
  logic reload;

  // ==========================================================
  // Prescaler tick
  assign tick = (pre_q == (div_slow_q ? 9'(sdc_pkg::PRESCALE_SLOW - 1) : 9'(sdc_pkg::PRESCALE_FAST - 1)));
  assign reload = force_load_i || (wr_i && !auto_reload_i);

  // ==========================================================
  // Load register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_o <= sdc_pkg::LOAD_RST;
    end else if (ce_i && wr_i) begin
      load_o <= wr_data_i;
    end
  end

  // ==========================================================
  // Count, prescaler and latched division
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= sdc_pkg::COUNT_IDLE;
      pre_q <= '0;
      div_slow_q <= 1'b0;
    end else if (ce_i) begin
      if (!en_i) begin
        count_o <= sdc_pkg::COUNT_IDLE;
        pre_q <= '0;
      end else if (reload) begin
        count_o <= force_load_i ? load_o : wr_data_i;
        div_slow_q <= div_slow_i;
        pre_q <= '0;
      end else if (tick) begin
        pre_q <= '0;
        if (count_o != sdc_pkg::COUNT_ZERO) begin
          count_o <= count_o - 1'b1;
        end else if (auto_reload_i) begin
          count_o <= load_o;
          div_slow_q <= div_slow_i;
        end
      end else begin
        pre_q <= pre_q + 9'h001;
      end
    end
  end

  // Underflow event only from a decrement, so loading zero raises nothing
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zero_hit_o <= 1'b0;
    end else if (ce_i) begin
      zero_hit_o <= en_i && !reload && tick && (count_o == 16'h0001);
    end
  end

  idle_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !en_i) |=> (count_o == sdc_pkg::COUNT_IDLE)) else $error("count not held idle");
  stop_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && en_i && !auto_reload_i && !reload && count_o == sdc_pkg::COUNT_ZERO)
    |=> (count_o == sdc_pkg::COUNT_ZERO)) else $error("one-shot count left zero");

endmodule : sdc_down_counter

// File: rtl/sdc_stall_ctl.sv
// Purpose: Stall detector coil switching and modulus counter control
// Assumes: AXI4-Lite slave, registers at index * 4, synchronous inputs
// Notes: Interrupt requests are plain levels for an outside controller
// ==========================================================
// Summary of operation
// - Drive coil pair per step during return
// - Recirculate other coil when not integrating
// - No integration means all routing switches open
// - Integration closes two switches by step, polarity
// - Undriven coil nodes routed, polarity swaps them
// - Step selects coil current sign when driving
// - Control register read/write; underflow irq enable
// - One-shot mode counts down, stops at zero
// - Modulus mode reloads from load at zero
// - Read source selects live count or load
// - Prescale divides bus clock by 64 or 512
// - Prescale change waits for next load
// - Force load copies load, reads zero
// - Disabled counter holds all ones
// - Overflow irq while enable and flag set
// - Return disabled releases every transistor
// - No integration resets converter and accumulator
// - Underflow sets flag; write one clears
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module sdc_stall_ctl #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // AXI4-Lite write address
  input wire logic [sdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [sdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Accumulator side
  input wire logic acc_overflow_i,
  output logic converter_reset_o,
  output logic acc_clear_o,
  // Coil side and interrupt requests
  output logic [7:0] transistor_on_o,
  output logic [7:0] switch_close_o,
  output logic underflow_irq_o,
  output logic acc_overflow_irq_o
);

  // ==========================================================
  // Declarations
  sdc_pkg::sdc_rtz_s rtz_q;
  sdc_pkg::sdc_coil_s coil_d;
  sdc_pkg::sdc_coil_s coil_q;
  logic [7:0] ctl_q;
  logic return_to_zero_en_q;
  logic underflow_flag_q;
  logic acc_overflow_flag_q;
  logic aw_have_q;
  logic w_have_q;
  logic [2:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [31:0] wmask;
  logic wr_rtz;
  logic wr_ctl;
  logic wr_stall;
  logic wr_flag;
  logic wr_cnt;
  logic force_load;
  logic [CNT_W-1:0] cnt_wdata;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] load;
  logic zero_hit;
  logic [31:0] rdata_d;
  logic [2:0] ar_idx;

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready = ce_i && !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = ce_i && !w_have_q && !s_axi_bvalid;
  assign s_axi_bresp = sdc_pkg::AXI_OKAY;
  assign do_write = ce_i && aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_have_q <= 1'b0;
      aw_idx_q <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[4:2];
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid <= 1'b0;
    end else if (ce_i) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte lanes of the write
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_rtz = do_write && wstrb_q[0] && (aw_idx_q == sdc_pkg::IDX_RTZ_CONTROL);
  assign wr_ctl = do_write && wstrb_q[0] && (aw_idx_q == sdc_pkg::IDX_DOWN_COUNTER_CONTROL);
  assign wr_stall = do_write && wstrb_q[0] && (aw_idx_q == sdc_pkg::IDX_STALL_CONTROL);
  assign wr_flag = do_write && wstrb_q[0] && (aw_idx_q == sdc_pkg::IDX_FLAGS);
  assign wr_cnt = do_write && (|wstrb_q[1:0]) && (aw_idx_q == sdc_pkg::IDX_DOWN_COUNTER_COUNT);
  // Lanes not written keep the old load value
  assign cnt_wdata = (wdata_q[CNT_W-1:0] & wmask[CNT_W-1:0]) | (load & ~wmask[CNT_W-1:0]);
  assign force_load = wr_ctl && wdata_q[sdc_pkg::BIT_FORCE_LOAD];

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rtz_q <= '0;
    end else if (ce_i && wr_rtz) begin
      rtz_q.integrate_sel <= wdata_q[sdc_pkg::BIT_INTEGRATE_SEL];
      rtz_q.drive_coil_en <= wdata_q[sdc_pkg::BIT_DRIVE_COIL_EN];
      rtz_q.recirc_low_side_sel <= wdata_q[sdc_pkg::BIT_RECIRC_LOW_SIDE_SEL];
      rtz_q.converter_polarity <= wdata_q[sdc_pkg::BIT_CONVERTER_POLARITY];
      rtz_q.step <= wdata_q[1:0];
    end
  end

  // Force-load bit is never stored, so it reads zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= sdc_pkg::RST_BYTE;
    end else if (ce_i && wr_ctl) begin
      ctl_q <= wdata_q[7:0] & 8'hF5;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      return_to_zero_en_q <= 1'b0;
    end else if (ce_i && wr_stall) begin
      return_to_zero_en_q <= wdata_q[sdc_pkg::BIT_RETURN_TO_ZERO_EN];
    end
  end

  // ==========================================================
  // Event flags, set wins over clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      underflow_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (zero_hit) begin
        underflow_flag_q <= 1'b1;
      end else if (wr_flag && wdata_q[sdc_pkg::BIT_UNDERFLOW_FLAG]) begin
        underflow_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_overflow_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (acc_overflow_i) begin
        acc_overflow_flag_q <= 1'b1;
      end else if (wr_flag && wdata_q[sdc_pkg::BIT_ACC_OVERFLOW_FLAG]) begin
        acc_overflow_flag_q <= 1'b0;
      end
    end
  end

  assign underflow_irq_o = ctl_q[sdc_pkg::BIT_UNDERFLOW_IRQ_EN] && underflow_flag_q;
  assign acc_overflow_irq_o = ctl_q[sdc_pkg::BIT_ACC_OVERFLOW_IRQ_EN] && acc_overflow_flag_q;

  // ==========================================================
  // Modulus down-counter
  // Mode change with the counter running is left to software
  sdc_down_counter #(
    .CNT_W(CNT_W)
  ) sdc_down_counter_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .en_i(ctl_q[sdc_pkg::BIT_DOWN_COUNTER_EN]),
    .auto_reload_i(ctl_q[sdc_pkg::BIT_AUTO_RELOAD_EN]),
    .div_slow_i(ctl_q[sdc_pkg::BIT_PRESCALE_SEL]),
    .wr_i(wr_cnt),
    .wr_data_i(cnt_wdata),
    .force_load_i(force_load),
    .count_o(count),
    .load_o(load),
    .zero_hit_o(zero_hit)
  );

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = ce_i && !s_axi_rvalid;
  assign s_axi_rresp = sdc_pkg::AXI_OKAY;
  assign ar_idx = s_axi_araddr[4:2];

  always_comb begin
    rdata_d = '0;
    unique case (ar_idx)
      sdc_pkg::IDX_RTZ_CONTROL: begin
        rdata_d[7:0] = {rtz_q.integrate_sel, rtz_q.drive_coil_en, rtz_q.recirc_low_side_sel,
                        rtz_q.converter_polarity, 2'h0, rtz_q.step};
      end
      sdc_pkg::IDX_DOWN_COUNTER_CONTROL: begin
        rdata_d[7:0] = ctl_q;
      end
      sdc_pkg::IDX_STALL_CONTROL: begin
        rdata_d[sdc_pkg::BIT_RETURN_TO_ZERO_EN] = return_to_zero_en_q;
      end
      sdc_pkg::IDX_FLAGS: begin
        rdata_d[sdc_pkg::BIT_UNDERFLOW_FLAG] = underflow_flag_q;
        rdata_d[sdc_pkg::BIT_ACC_OVERFLOW_FLAG] = acc_overflow_flag_q;
      end
      sdc_pkg::IDX_DOWN_COUNTER_COUNT: begin
        rdata_d[CNT_W-1:0] = ctl_q[sdc_pkg::BIT_READ_LOAD_SEL] ? load : count;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Coil transistor and routing switch decode
  always_comb begin
    coil_d = '0;
    if (return_to_zero_en_q) begin
      if (rtz_q.drive_coil_en) begin
        // Step sets which coil and which current sign
        unique case (rtz_q.step)
          2'h0: coil_d.transistor_on = coil_d.transistor_on | 8'h09;
          2'h1: coil_d.transistor_on = coil_d.transistor_on | 8'h90;
          2'h2: coil_d.transistor_on = coil_d.transistor_on | 8'h06;
          2'h3: coil_d.transistor_on = coil_d.transistor_on | 8'h60;
        endcase
      end
      // Integrating leaves the other coil floating
      if (!rtz_q.integrate_sel) begin
        if (!rtz_q.step[0]) begin
          coil_d.transistor_on = coil_d.transistor_on | (rtz_q.recirc_low_side_sel ? 8'hA0 : 8'h50);
        end else begin
          coil_d.transistor_on = coil_d.transistor_on | (rtz_q.recirc_low_side_sel ? 8'h0A : 8'h05);
        end
      end
    end
    // Routing ignores the return enable
    if (rtz_q.integrate_sel) begin
      unique case ({rtz_q.step, rtz_q.converter_polarity})
        3'h0: coil_d.switch_close = 8'h90;
        3'h1: coil_d.switch_close = 8'h60;
        3'h2: coil_d.switch_close = 8'h06;
        3'h3: coil_d.switch_close = 8'h09;
        3'h4: coil_d.switch_close = 8'h60;
        3'h5: coil_d.switch_close = 8'h90;
        3'h6: coil_d.switch_close = 8'h09;
        3'h7: coil_d.switch_close = 8'h06;
      endcase
    end
  end

  // Registered so the bridge never sees a decode glitch
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      coil_q <= '0;
    end else if (ce_i) begin
      coil_q <= coil_d;
    end
  end

  assign transistor_on_o = coil_q.transistor_on;
  assign switch_close_o = coil_q.switch_close;
  assign converter_reset_o = !rtz_q.integrate_sel;
  assign acc_clear_o = !rtz_q.integrate_sel;

  // ==========================================================
  // Checks
  rtz_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !return_to_zero_en_q) |=> (transistor_on_o == 8'h00)) else $error("transistor on with return off");
  drive_pair_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && return_to_zero_en_q && rtz_q.drive_coil_en && rtz_q.step == 2'h1)
    |=> (transistor_on_o[4] && transistor_on_o[7])) else $error("step one drive pair missing");
  recirc_pair_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && return_to_zero_en_q && !rtz_q.integrate_sel && rtz_q.step == 2'h0 && rtz_q.recirc_low_side_sel)
    |=> (transistor_on_o[5] && transistor_on_o[7] && !transistor_on_o[4])) else $error("recirculation pair wrong");
  float_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && rtz_q.integrate_sel && !rtz_q.drive_coil_en) |=> (transistor_on_o == 8'h00))
    else $error("transistor on while floating");
  switch_open_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !rtz_q.integrate_sel) |=> (switch_close_o == 8'h00)) else $error("switch closed without integration");
  switch_two_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && rtz_q.integrate_sel) |=> ($countones(switch_close_o) == 2)) else $error("not two switches closed");
  polarity_swap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && rtz_q.integrate_sel && rtz_q.step == 2'h2 && !rtz_q.converter_polarity)
    |=> (switch_close_o == 8'h60)) else $error("step two routing wrong");
  uf_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    underflow_irq_o == (ctl_q[7] && underflow_flag_q)) else $error("underflow request mismatch");
  uf_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && zero_hit) |=> underflow_flag_q) else $error("underflow flag not set");
  force_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ctl_q[sdc_pkg::BIT_FORCE_LOAD]) else $error("force load bit stored");
  ov_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ctl_q[0] && acc_overflow_flag_q) |-> acc_overflow_irq_o) else $error("overflow request missing");
  conv_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !rtz_q.integrate_sel |-> (converter_reset_o && acc_clear_o)) else $error("converter not reset");

endmodule : sdc_stall_ctl

// File: tb/sdc_coil_model.sv
// Purpose: Behavioural half-bridges of the cosine and sine coils
// Assumes: T1-T4 bridge the cosine coil, T5-T8 the sine coil
// Notes: Node codes 1 cos+, 2 cos-, 3 sin+, 4 sin-, 0 none routed
`timescale 1ns/10ps
module sdc_coil_model (
  input wire logic [7:0] transistor_on_i,
  input wire logic [7:0] switch_close_i,
  output logic signed [1:0] cos_cur_o,
  output logic signed [1:0] sin_cur_o,
  output logic [2:0] integ_node_o,
  output logic [2:0] ref_node_o
);
  // ==========================================================
  // Coil current
  // Only a diagonal pair passes current; a same-side pair recirculates
  function automatic logic signed [1:0] coil_cur(input logic [3:0] t);
    return (t == 4'h9) ? 2'sh1 : ((t == 4'h6) ? 2'sh3 : 2'sh0);
  endfunction : coil_cur

  assign cos_cur_o = coil_cur(transistor_on_i[3:0]);
  assign sin_cur_o = coil_cur(transistor_on_i[7:4]);

  // ==========================================================
  // Converter routing, odd switch to integrator, even to reference
  always_comb begin
    integ_node_o = 3'h0;
    ref_node_o = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (switch_close_i[2*i+1]) integ_node_o = 3'(i + 1);
      if (switch_close_i[2*i]) ref_node_o = 3'(i + 1);
    end
  end
endmodule : sdc_coil_model

// File: tb/sdc_stall_ctl_tb.sv
// Purpose: Self-checking bench for coil switching and down-counter control
// Assumes: Register bus speaks AXI4-Lite, byte address is index times four
// Notes: Counter reads are taken mid-tick so a few cycles of skew are harmless
`timescale 1ns/10ps
module sdc_stall_ctl_tb;
  logic clk_i, nrst_i, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic ce, acc_ov, conv_rst, acc_clr, uf_irq, ov_irq;
  logic [1:0] bresp, rresp;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0] transistor_on, switch_close;
  logic signed [1:0] cos_cur, sin_cur;
  logic [2:0] integ_node, ref_node;
  int total_checks, miscompares;
  logic [7:0] drv_tab [4] = '{8'h09, 8'h90, 8'h06, 8'h60};
  logic [7:0] sw_tab [8] = '{8'h90, 8'h60, 8'h06, 8'h09, 8'h60, 8'h90, 8'h09, 8'h06};
  logic [5:0] node_tab [8] = '{6'h23, 6'h1C, 6'h0A, 6'h11, 6'h1C, 6'h23, 6'h11, 6'h0A};
  logic [3:0] cur_tab [4] = '{4'h4, 4'h1, 4'hC, 4'h3};

  sdc_stall_ctl sdc_stall_ctl_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .acc_overflow_i(acc_ov), .converter_reset_o(conv_rst), .acc_clear_o(acc_clr),
    .transistor_on_o(transistor_on), .switch_close_o(switch_close),
    .underflow_irq_o(uf_irq), .acc_overflow_irq_o(ov_irq));

  sdc_coil_model sdc_coil_model_i (.transistor_on_i(transistor_on), .switch_close_i(switch_close),
    .cos_cur_o(cos_cur), .sin_cur_o(sin_cur), .integ_node_o(integ_node), .ref_node_o(ref_node));

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // Handshakes sampled at the falling edge so the rising edge never races
  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    logic a, w, b;
    logic [1:0] rsp;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rsp = bresp;
      @(posedge clk_i);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    chk({30'h0, rsp}, 32'h0, "write response");
  endtask : wr

  task automatic rc(input logic [2:0] idx, input logic [31:0] exp, input string m);
    logic a, r;
    logic [1:0] rr;
    logic [31:0] d;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      a = arvalid && arready;
      r = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge clk_i);
      if (a) arvalid <= 1'b0;
    end while (!r);
    chk(d, exp, m);
    chk({30'h0, rr}, 32'h0, "read response");
  endtask : rc

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Coil decode over every step, mode and enable combination
  task automatic coil_test();
    logic [6:0] c;
    logic [7:0] t, rec;
    for (int i = 0; i < 128; i++) begin
      c = 7'(i);
      wr(3'h2, {24'h0, c[6], 7'h0});
      wr(3'h0, {24'h0, c[5:2], 2'h0, c[1:0]});
      wt(2);
      rec = c[0] ? (c[3] ? 8'h0A : 8'h05) : (c[3] ? 8'hA0 : 8'h50);
      t = c[6] ? ((c[4] ? drv_tab[c[1:0]] : 8'h00) | (c[5] ? 8'h00 : rec)) : 8'h00;
      chk({16'h0, transistor_on, switch_close}, {16'h0, t, c[5] ? sw_tab[{c[1:0], c[2]}] : 8'h00}, "decode");
      chk({30'h0, conv_rst, acc_clr}, {30'h0, {2{!c[5]}}}, "converter reset");
      chk({22'h0, cos_cur, sin_cur, integ_node, ref_node}, {22'h0, (c[6] && c[4]) ? cur_tab[c[1:0]] : 4'h0,
        c[5] ? node_tab[{c[1:0], c[2]}] : 6'h00}, "coil model");
    end
    $display("coil test done");
  endtask : coil_test

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst_i, awvalid, wvalid, arvalid, acc_ov} = 5'h00;
    ce = 1'b1;
    {awaddr, araddr, wdata} = 42'h0;
    total_checks = 0;
    miscompares = 0;
    wt(6);
    nrst_i <= 1'b1;
    wt(1);
    rc(3'h1, 32'h0, "control reset");
    rc(3'h4, 32'hFFFF, "idle count");
    rc(3'h5, 32'h0, "unmapped");
    coil_test();
    wr(3'h1, 32'h04);
    wr(3'h4, 32'h64);
    wt(160);
    rc(3'h4, 32'h62, "count at div 64");
    wr(3'h1, 32'h14);
    wt(128);
    rc(3'h4, 32'h60, "prescale waits for load");
    wr(3'h1, 32'h1C);
    rc(3'h1, 32'h14, "force load reads zero");
    wt(600);
    rc(3'h4, 32'h63, "count at div 512");
    wr(3'h1, 32'h34);
    rc(3'h4, 32'h64, "load readback");
    $display("prescale test done");
    wr(3'h1, 32'h04);
    wr(3'h4, 32'h2);
    wt(300);
    rc(3'h4, 32'h0, "one shot stops");
    rc(3'h3, 32'h80, "underflow flag");
    chk({31'h0, uf_irq}, 32'h0, "irq masked");
    wr(3'h1, 32'h84);
    chk({31'h0, uf_irq}, 32'h1, "irq raised");
    wr(3'h3, 32'h00);
    rc(3'h3, 32'h80, "zero write keeps flag");
    wr(3'h3, 32'h80);
    chk({31'h0, uf_irq}, 32'h0, "irq cleared");
    $display("one shot test done");
    wr(3'h1, 32'h00);
    rc(3'h4, 32'hFFFF, "disabled all ones");
    wr(3'h1, 32'h40);
    wr(3'h4, 32'h2);
    rc(3'h4, 32'hFFFF, "auto write load only");
    wr(3'h1, 32'h44);
    wr(3'h1, 32'h4C);
    wt(283);
    rc(3'h4, 32'h1, "reloaded");
    rc(3'h3, 32'h80, "reload flag");
    $display("auto reload test done");
    acc_ov <= 1'b1;
    wt(1);
    acc_ov <= 1'b0;
    rc(3'h3, 32'h81, "overflow flag");
    chk({31'h0, ov_irq}, 32'h0, "overflow masked");
    wr(3'h1, 32'h01);
    chk({31'h0, ov_irq}, 32'h1, "overflow irq");
    wr(3'h3, 32'h01);
    chk({31'h0, ov_irq}, 32'h0, "overflow cleared");
    $display("overflow test done");
    wr(3'h1, 32'h04);
    wr(3'h4, 32'h10);
    ce <= 1'b0;
    wt(200);
    ce <= 1'b1;
    rc(3'h4, 32'h10, "count frozen");
    $display("clock enable test done");
    test_done();
  end
endmodule : sdc_stall_ctl_tb
